// ===== src/reset_cause_pkg.sv
/*
  Package for the reset-cause flag block: register offsets, field positions,
  reset values, the AXI4-Lite response codes and the carriers shared by the files.
  Assumes a 32-bit AXI4-Lite bus, with one register word per aligned address.
*/
package reset_cause_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [3:0] flags_offset  = 4'h0;
  localparam logic [3:0] events_offset = 4'h4;

  // ------------------------------------------------------------------
  // Field positions in the flag register
  // ------------------------------------------------------------------
  localparam int stack_over_bit  = 7;
  localparam int stack_under_bit = 6;
  localparam int unused_bit      = 5;
  localparam int watchdog_bit    = 4;
  localparam int pin_bit         = 3;
  localparam int instr_bit       = 2;
  localparam int power_on_bit    = 1;
  localparam int brownout_bit    = 0;

  // Bits that firmware can store; bit 5 is never stored.
  localparam logic [7:0] implemented_mask = 8'hdf;

  // Value taken on power-on and brown-out, before the cause bits are cleared.
  localparam logic [7:0] power_reset_value = 8'h1f;

  // ------------------------------------------------------------------
  // AXI4-Lite response codes
  // ------------------------------------------------------------------
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic low_power_brownout;
    logic pin;
    logic watchdog;
    logic instr;
    logic stack_over;
    logic stack_under;
  } reset_events_s;

  typedef struct packed {
    logic       write;
    logic [7:0] data;
  } flag_write_s;

endpackage

// ===== src/reset_event_decode.sv
/*
  Combines the raw reset sources into the events that move the flags and into
  the single request that resets the rest of the device.
  Assumes every source is a level synchronous to aclk, high while active.
*/
`timescale 1ns/100ps

module reset_event_decode (
  input  wire logic                          stack_reset_enable,
  input  wire reset_cause_pkg::reset_events_s raw,
  output      reset_cause_pkg::reset_events_s events,
  output      logic                          device_reset_req
);

  wire brownout_any = raw.brownout | raw.low_power_brownout;
  wire stack_reset  = stack_reset_enable & (raw.stack_over | raw.stack_under);

  assign events.power_on           = raw.power_on;
  assign events.brownout           = brownout_any;
  assign events.low_power_brownout = raw.low_power_brownout;
  assign events.pin                = raw.pin;
  assign events.watchdog           = raw.watchdog;
  assign events.instr              = raw.instr;
  assign events.stack_over         = raw.stack_over;
  assign events.stack_under        = raw.stack_under;

  assign device_reset_req = raw.power_on | brownout_any | raw.pin | raw.watchdog
                          | raw.instr | stack_reset;

endmodule

// ===== src/reset_cause_flags_core.sv
/*
  The flag register itself: hardware sets the stack flags, clears the cause
  flags, and firmware may write any implemented bit.
  Assumes events are levels synchronous to aclk; held events keep acting.
*/
`timescale 1ns/100ps

module reset_cause_flags_core (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire reset_cause_pkg::reset_events_s events,
  input  wire reset_cause_pkg::flag_write_s   wr,
  output      logic [7:0]                     flags
);

  logic [7:0] flags_reg;
  logic [7:0] base;
  logic [7:0] flags_next;
  logic       power_event;

  assign power_event = events.power_on | events.brownout;

  // Power-on and brown-out load fixed values in place of any firmware write, then the
  // hardware events apply on top, so a cause arriving with a write is never lost.
  always_comb begin
    base = flags_reg;
    if (power_event) begin
      // A brown-out alone leaves the power-on flag as it was, so firmware can
      // still tell a fresh power-up from a later supply dip.
      base = reset_cause_pkg::power_reset_value;
      base[reset_cause_pkg::power_on_bit] = flags_reg[reset_cause_pkg::power_on_bit];
    end else if (wr.write) begin
      base = wr.data & reset_cause_pkg::implemented_mask;
    end
    flags_next = base;
    if (events.stack_over) begin
      flags_next[reset_cause_pkg::stack_over_bit] = 1'b1;
    end
    if (events.stack_under) begin
      flags_next[reset_cause_pkg::stack_under_bit] = 1'b1;
    end
    if (events.watchdog) begin
      flags_next[reset_cause_pkg::watchdog_bit] = 1'b0;
    end
    if (events.pin) begin
      flags_next[reset_cause_pkg::pin_bit] = 1'b0;
    end
    if (events.instr) begin
      flags_next[reset_cause_pkg::instr_bit] = 1'b0;
    end
    if (events.power_on) begin
      flags_next[reset_cause_pkg::power_on_bit] = 1'b0;
    end
    if (power_event) begin
      flags_next[reset_cause_pkg::brownout_bit] = 1'b0;
    end
    flags_next[reset_cause_pkg::unused_bit] = 1'b0;
  end

  // The bus reset loads the power-on pattern; causes are captured on the
  // same edges that request the device reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= reset_cause_pkg::power_reset_value & 8'hfc;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

// ===== src/reset_cause_flag_register.sv
/*
  Reset-cause flag register with an AXI4-Lite slave.
  Assumes all reset sources are synchronous levels on aclk. The aresetn input
  resets the bus logic and loads the flags with the power-on pattern; after
  that only the reset sources and firmware writes move them.
*/
// Contract
// - Stack overflow sets bit 7 until cleared.
// - Stack underflow sets bit 6 until cleared.
// - Bit 5 reads zero, writes ignored.
// - Watchdog reset clears bit 4.
// - Pin reset clears bit 3.
// - Reset instruction clears bit 2.
// - Power-on clears bit 1; firmware rewrites.
// - Brown-out clears bit 0; firmware rewrites.
// - Power resets load fixed flag values.
// - Hardware sets stack flags, clears others.
// - Both brown-out detectors clear bit 0.
// - Stack faults reset only when enabled.
`timescale 1ns/100ps

module reset_cause_flag_register (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        power_on_reset,
  input  wire logic        brownout_reset,
  input  wire logic        low_power_brownout_detector,
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire logic        reset_instruction,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  input  wire logic        stack_reset_enable,
  output      logic        device_reset,
  output      logic [7:0]  reset_cause_flags
);

  // ------------------------------------------------------------------
  // Reset sources
  // ------------------------------------------------------------------
  reset_cause_pkg::reset_events_s raw;
  reset_cause_pkg::reset_events_s events;
  reset_cause_pkg::flag_write_s   flag_wr;
  logic                           reset_req;
  logic [7:0]                     flags;

  assign raw.power_on           = power_on_reset;
  assign raw.brownout           = brownout_reset;
  assign raw.low_power_brownout = low_power_brownout_detector;
  assign raw.pin                = ~external_reset_pin_n;
  assign raw.watchdog           = watchdog_timeout;
  assign raw.instr              = reset_instruction;
  assign raw.stack_over         = stack_overflow;
  assign raw.stack_under        = stack_underflow;

  reset_event_decode u_decode (
    .stack_reset_enable (stack_reset_enable),
    .raw                (raw),
    .events             (events),
    .device_reset_req   (reset_req)
  );

  reset_cause_flags_core u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .events  (events),
    .wr      (flag_wr),
    .flags   (flags)
  );

  // ------------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------------
  logic        aw_held_reg;
  logic [3:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        awready_reg;
  logic        wready_reg;

  // Word decode shared by the write and read paths; the byte offset is ignored.
  function automatic logic hits(input logic [3:0] addr, input logic [3:0] offset);
    return addr[3:2] == offset[3:2];
  endfunction

  wire aw_take   = s_axi_awvalid & ~aw_held_reg & ~bvalid_reg;
  wire w_take    = s_axi_wvalid & ~w_held_reg & ~bvalid_reg;
  wire wr_go     = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire wr_flags  = hits(aw_addr_reg, reset_cause_pkg::flags_offset);
  wire wr_events = hits(aw_addr_reg, reset_cause_pkg::events_offset);
  wire wr_mapped = wr_flags | wr_events;

  // Only byte lane 0 carries the flags; a write without it leaves them alone.
  assign flag_wr.write = wr_go & wr_flags & w_strb_reg[0];
  assign flag_wr.data  = w_data_reg[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= reset_cause_pkg::resp_okay;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? reset_cause_pkg::resp_okay : reset_cause_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // The readies are flops fed with the next holding state, so the handshake
  // timing is that of the holding flags while the ports come from a register.
  wire aw_held_next = aw_take | (aw_held_reg & ~wr_go);
  wire w_held_next  = w_take | (w_held_reg & ~wr_go);
  wire bvalid_next  = wr_go | (bvalid_reg & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end else begin
      awready_reg <= ~aw_held_next & ~bvalid_next;
      wready_reg  <= ~w_held_next & ~bvalid_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        arready_reg;

  wire        ar_take   = s_axi_arvalid & ~rvalid_reg;
  wire        rd_flags  = hits(s_axi_araddr, reset_cause_pkg::flags_offset);
  wire        rd_events = hits(s_axi_araddr, reset_cause_pkg::events_offset);
  wire [31:0] rd_value  = rd_flags  ? {24'h0, flags} :
                          rd_events ? {24'h0, events} : 32'h0;
  wire        rd_mapped = rd_flags | rd_events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= reset_cause_pkg::resp_okay;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= rd_mapped ? reset_cause_pkg::resp_okay : reset_cause_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
    end else begin
      arready_reg <= ~rvalid_next;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ------------------------------------------------------------------
  // Device-side outputs
  // ------------------------------------------------------------------
  logic device_reset_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_reset_reg <= 1'b0;
    end else begin
      device_reset_reg <= reset_req;
    end
  end

  assign device_reset      = device_reset_reg;
  assign reset_cause_flags = flags;

endmodule

// ===== tb/reset_cause_sva.sv
/*
  Checker for the reset-cause flag register: flag set and clear effects,
  the fixed loads of power resets and the gating of the device reset request.
  Assumes it is bound to the top module and all sources are levels on aclk.
*/
`timescale 1ns/100ps

module reset_cause_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       power_on_reset,
  input wire logic       brownout_reset,
  input wire logic       low_power_brownout_detector,
  input wire logic       external_reset_pin_n,
  input wire logic       watchdog_timeout,
  input wire logic       reset_instruction,
  input wire logic       stack_overflow,
  input wire logic       stack_underflow,
  input wire logic       stack_reset_enable,
  input wire logic       device_reset,
  input wire logic [7:0] reset_cause_flags
);
  // ------------------------------------------------------------------
  // Helper terms
  // ------------------------------------------------------------------
  wire logic other_src = power_on_reset | brownout_reset | low_power_brownout_detector |
                         !external_reset_pin_n | watchdog_timeout | reset_instruction;
  wire logic any_evt   = other_src | stack_overflow | stack_underflow;
  wire logic brown_any = brownout_reset | low_power_brownout_detector;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  ovf_flag_set_a: assert property (
    stack_overflow |=> reset_cause_flags[7]) else $error("overflow flag not set");
  unf_flag_set_a: assert property (
    stack_underflow |=> reset_cause_flags[6]) else $error("underflow flag not set");
  spare_bit_zero_a: assert property (
    reset_cause_flags[5] == 1'b0) else $error("spare bit not zero");
  wdt_flag_clear_a: assert property (
    watchdog_timeout |=> !reset_cause_flags[4]) else $error("watchdog flag not cleared");
  pin_flag_clear_a: assert property (
    !external_reset_pin_n |=> !reset_cause_flags[3]) else $error("pin flag not cleared");
  instr_flag_clear_a: assert property (
    reset_instruction |=> !reset_cause_flags[2]) else $error("instr flag not cleared");
  power_on_load_a: assert property (
    power_on_reset |=> reset_cause_flags == 8'h1c) else $error("power-on load wrong");
  brownout_load_a: assert property (
    brown_any && !power_on_reset |=> reset_cause_flags[7:2] == 6'h07 &&
    !reset_cause_flags[0] && reset_cause_flags[1] == $past(reset_cause_flags[1]))
    else $error("brown-out load wrong");
  reset_request_a: assert property (
    other_src |=> device_reset) else $error("device reset not requested");
  stack_gate_a: assert property (
    (stack_overflow || stack_underflow) && !stack_reset_enable && !other_src
    |=> !device_reset) else $error("stack fault reset while disabled");
  flag_hold_a: assert property (
    !$past(any_evt) && !$rose(s_axi_bvalid) |-> $stable(reset_cause_flags))
    else $error("flags changed with no cause");
endmodule

// ===== tb/reset_cause_flag_register_tb.sv
/*
  Self-checking bench for the reset-cause flag register over AXI4-Lite.
  Assumes the design package and the checker are compiled first.
*/
`timescale 1ns/100ps

module reset_cause_flag_register_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, stack_reset_enable, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, device_reset;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [7:0]  reset_cause_flags, src;
  int          miscompares, checks;
  localparam logic [7:0] exp_t [8] = '{8'h5f, 8'h9f, 8'h1b, 8'h0f, 8'h17, 8'h1c, 8'h1e, 8'h1c};

  // Source bits follow the event order: power, brown, lp, pin, wdt, instr, ovf, unf.
  reset_cause_flag_register u_reset_cause_flag_register (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_on_reset(src[7]),
    .brownout_reset(src[6]), .low_power_brownout_detector(src[5]),
    .external_reset_pin_n(~src[4]), .watchdog_timeout(src[3]),
    .reset_instruction(src[2]), .stack_overflow(src[1]), .stack_underflow(src[0]),
    .stack_reset_enable, .device_reset, .reset_cause_flags);

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    if (s_axi_bvalid !== 1'b1) begin
      chk("write response", 32'h1, 32'h0);
      end_sim();
    end
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    if (s_axi_rvalid !== 1'b1) begin
      chk("read response", 32'h1, 32'h0);
      end_sim();
    end
    chk("rdata", {24'h0, ed}, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle source pulse; returns just after the edge that registers its effect.
  task automatic fire(input logic [7:0] m);
    @(posedge aclk);
    src <= m;
    @(posedge aclk);
    src <= 8'h00;
    #1;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_firmware;
    chk("flags after reset", 32'h1c, 32'(reset_cause_flags));
    axi_wr(reset_cause_pkg::flags_offset, 8'hff, reset_cause_pkg::resp_okay);
    axi_rd(reset_cause_pkg::flags_offset, 8'hdf, reset_cause_pkg::resp_okay);
    axi_wr(reset_cause_pkg::flags_offset, 8'h00, reset_cause_pkg::resp_okay);
    axi_rd(reset_cause_pkg::flags_offset, 8'h00, reset_cause_pkg::resp_okay);
    $display("test firmware done");
  endtask

  task automatic t_causes;
    for (int i = 0; i < 8; i++) begin
      axi_wr(reset_cause_pkg::flags_offset, (i < 5) ? 8'h1f : (i == 6) ? 8'hc2 : 8'hc0,
             reset_cause_pkg::resp_okay);
      fire(8'(8'h01 << i));
      chk("device reset", 32'h1, 32'(device_reset));
      chk("flags", 32'(exp_t[i]), 32'(reset_cause_flags));
      axi_rd(reset_cause_pkg::flags_offset, exp_t[i], reset_cause_pkg::resp_okay);
    end
    $display("test causes done");
  endtask

  task automatic t_stack_gate;
    @(posedge aclk);
    stack_reset_enable <= 1'b0;
    axi_wr(reset_cause_pkg::flags_offset, 8'h1f, reset_cause_pkg::resp_okay);
    fire(8'h02);
    chk("gated reset", 32'h0, 32'(device_reset));
    fire(8'h01);
    chk("gated reset", 32'h0, 32'(device_reset));
    axi_rd(reset_cause_pkg::flags_offset, 8'hdf, reset_cause_pkg::resp_okay);
    stack_reset_enable <= 1'b1;
    $display("test stack gate done");
  endtask

  task automatic t_map;
    axi_rd(4'h8, 8'h00, reset_cause_pkg::resp_slverr);
    axi_wr(4'h8, 8'h00, reset_cause_pkg::resp_slverr);
    axi_rd(reset_cause_pkg::flags_offset, 8'hdf, reset_cause_pkg::resp_okay);
    s_axi_wstrb <= 4'he;
    axi_wr(reset_cause_pkg::flags_offset, 8'h00, reset_cause_pkg::resp_okay);
    s_axi_wstrb <= 4'hf;
    axi_rd(reset_cause_pkg::flags_offset, 8'hdf, reset_cause_pkg::resp_okay);
    @(posedge aclk);
    src <= 8'h08;
    axi_rd(reset_cause_pkg::events_offset, 8'h08, reset_cause_pkg::resp_okay);
    src <= 8'h00;
    $display("test map done");
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src} = '0;
    s_axi_wstrb        = 4'hf;
    stack_reset_enable = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_firmware();
    t_causes();
    t_stack_gate();
    t_map();
    end_sim();
  end
endmodule

bind reset_cause_flag_register reset_cause_sva u_reset_cause_sva (
  .aclk, .aresetn, .s_axi_bvalid, .power_on_reset, .brownout_reset,
  .low_power_brownout_detector, .external_reset_pin_n, .watchdog_timeout,
  .reset_instruction, .stack_overflow, .stack_underflow, .stack_reset_enable,
  .device_reset, .reset_cause_flags);
